// ===== core/adc_seq_pkg.sv
// Constants shared by the two-channel converter sequencer
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Output word layout and counter width
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 32;
  localparam int CODE_BITS = 30;
  localparam int CNT_W = 16;
  localparam logic [5:0] LAST_BIT = 6'h1f;
  localparam logic [29:0] OVER_CODE = 30'h3000_0000;
  localparam logic [29:0] UNDER_CODE = 30'h0fff_ffff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int OSC50_HZ = 128_000;
  localparam int OSC60_HZ = 153_600;
  localparam int TICK50_CYC = CLK_HZ / OSC50_HZ;
  localparam int TICK60_CYC = CLK_HZ / OSC60_HZ;
  localparam int SCK_DIV = 8;
  localparam int SCK_HALF_TICKS = SCK_DIV / 2;
  localparam int CONV_TICKS = 20510;
  localparam int CAL_TICKS = 2048;
  localparam int POR_TIME_US = 1000;
  localparam int POR_CYC = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam int EXT_LOW_MAX_US = 390;
  localparam int EXT_HOLD_CYC = EXT_LOW_MAX_US * (CLK_HZ / 1_000_000) + 1;

endpackage

// ===== core/adc_sequencer.sv
// Conversion, sleep and serial read-out sequencer of a two-channel converter
`timescale 1ns/1ps

// What this block does
// - Channel 0 first, then alternate channels
// - Cycle: convert, sleep, data output, repeat
// - Sleep after conversion while select high
// - Result held unchanged during sleep
// - Select low drives output, wakes to read-out
// - Select high before first rise: sleep
// - Select low at first rise commits read
// - Select rise mid-transfer aborts, starts conversion
// - Output changes on falling serial clock
// - Read-out ends after 32 bits or select high
// - Result belongs to conversion just finished
// - Data output floats while select high
// - Status shown on output outside read-out
// - Internal mode drives clock, enables pull-up
// - External mode takes clock from host
// - Clock mode sampled at reset, select fall
// - Frequency pin high 50Hz, low 60Hz timing
// - Toggling frequency pin becomes system clock
// - Distinct overrange and underrange codes
// - Calibration inside conversion, timing unchanged
// - Power-on reset clears state, channel 0
// - No configuration registers, pin timing only
// - Word: done, channel, sign, 24 bits, 5 sub
// - Done flag high converting, low when finished
// - After 32nd falling edge output goes high
// - Internal serial clock is system clock / 8
module adc_sequencer #(
  parameter int CONV_TICKS = adc_seq_pkg::CONV_TICKS,
  parameter int POR_CYC = adc_seq_pkg::POR_CYC,
  parameter int EXT_HOLD_CYC = adc_seq_pkg::EXT_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  output logic sck_pullup_en,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic notch_freq_select_pin,
  input wire logic [adc_seq_pkg::CODE_BITS-1:0] fe_code,
  input wire logic fe_over,
  input wire logic fe_under,
  output logic conv_busy,
  output logic cal_active,
  output logic chan_sel,
  output logic ext_osc_active
);

  typedef enum logic [1:0] {S_POR, S_CONV, S_SLEEP, S_OUT} st_t;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic cs_n_s;
  logic sck_s;
  logic notch_s;

  sync2 #(.RST_VAL(1'b1)) u_sync_cs (.clk(clk), .rst(rst), .d(cs_n), .q(cs_n_s));
  sync2 #(.RST_VAL(1'b1)) u_sync_sck (.clk(clk), .rst(rst), .d(sck_in), .q(sck_s));
  sync2 #(.RST_VAL(1'b0)) u_sync_f0 (
    .clk(clk),
    .rst(rst),
    .d(notch_freq_select_pin),
    .q(notch_s)
  );

  // ----------------------------------------------------------------
  // System time base
  // ----------------------------------------------------------------
  logic notch_q_r, notch_q_nxt;
  logic sck_q_r, sck_q_nxt;
  logic [adc_seq_pkg::CNT_W-1:0] div_r, div_nxt;
  logic [adc_seq_pkg::CNT_W-1:0] ext_hold_r, ext_hold_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    notch_q_nxt = notch_s;
    sck_q_nxt = sck_s;
    ext_hold_nxt = ext_hold_r;
    div_nxt = div_r + 16'h0001;
    tick_nxt = 1'b0;
    // Any pin edge means an oscillator is driving it
    if (notch_s != notch_q_r) begin
      ext_hold_nxt = adc_seq_pkg::CNT_W'(EXT_HOLD_CYC);
    end else if (ext_hold_r != 16'h0000) begin
      ext_hold_nxt = ext_hold_r - 16'h0001;
    end
    if (ext_hold_r != 16'h0000) begin
      div_nxt = 16'h0000;
      tick_nxt = notch_s & ~notch_q_r;
    end else if ((notch_s && div_r == 16'(adc_seq_pkg::TICK50_CYC - 1)) ||
                 (!notch_s && div_r == 16'(adc_seq_pkg::TICK60_CYC - 1))) begin
      div_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      notch_q_r <= 1'b0;
      sck_q_r <= 1'b1;
      div_r <= 16'h0000;
      ext_hold_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      notch_q_r <= notch_q_nxt;
      sck_q_r <= sck_q_nxt;
      div_r <= div_nxt;
      ext_hold_r <= ext_hold_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign ext_osc_active = (ext_hold_r != 16'h0000);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  st_t st_r, st_nxt;
  logic ch_r, ch_nxt;
  logic [31:0] shift_r, shift_nxt;
  logic [5:0] bit_cnt_r, bit_cnt_nxt;
  logic committed_r, committed_nxt;
  logic ext_mode_r, ext_mode_nxt;
  logic [adc_seq_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic isck_r, isck_nxt;
  logic [1:0] half_r, half_nxt;
  logic sdo_r, sdo_nxt;
  logic cs_q_r;
  logic sck_rise;
  logic sck_fall;
  logic [adc_seq_pkg::CODE_BITS-1:0] code_sel;

  always_comb begin
    st_nxt = st_r;
    ch_nxt = ch_r;
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    committed_nxt = committed_r;
    ext_mode_nxt = ext_mode_r;
    cnt_nxt = cnt_r;
    isck_nxt = isck_r;
    half_nxt = half_r;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    // Clamped codes for inputs beyond full scale
    if (fe_over) begin
      code_sel = adc_seq_pkg::OVER_CODE;
    end else if (fe_under) begin
      code_sel = adc_seq_pkg::UNDER_CODE;
    end else begin
      code_sel = fe_code;
    end
    // Serial clock edges, from the host or from our own divider
    if (ext_mode_r) begin
      sck_rise = sck_s & ~sck_q_r;
      sck_fall = ~sck_s & sck_q_r;
    end else if (st_r == S_OUT && !cs_n_s && tick_r) begin
      if (half_r == 2'(adc_seq_pkg::SCK_HALF_TICKS - 1)) begin
        half_nxt = 2'h0;
        isck_nxt = ~isck_r;
        sck_rise = ~isck_r;
        sck_fall = isck_r;
      end else begin
        half_nxt = half_r + 2'h1;
      end
    end
    // Clock mode follows the pin level at each select fall
    if (!cs_n_s && cs_q_r) begin
      ext_mode_nxt = ~sck_s;
    end
    unique case (st_r)
      S_POR: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == adc_seq_pkg::CNT_W'(POR_CYC - 1)) begin
          st_nxt = S_CONV;
          cnt_nxt = 16'h0000;
          ext_mode_nxt = ~sck_s;
        end
      end
      S_CONV: begin
        if (tick_r) begin
          cnt_nxt = cnt_r + 16'h0001;
          if (cnt_r == adc_seq_pkg::CNT_W'(CONV_TICKS - 1)) begin
            st_nxt = S_SLEEP;
            shift_nxt = {1'b0, ch_r, code_sel};
          end
        end
      end
      S_SLEEP: begin
        if (!cs_n_s) begin
          st_nxt = S_OUT;
          bit_cnt_nxt = 6'h00;
          committed_nxt = 1'b0;
          half_nxt = 2'h0;
          isck_nxt = 1'b0;
        end
      end
      S_OUT: begin
        if (cs_n_s) begin
          isck_nxt = 1'b0;
          if (committed_r) begin
            st_nxt = S_CONV;
            cnt_nxt = 16'h0000;
            ch_nxt = ~ch_r;
          end else begin
            st_nxt = S_SLEEP;
          end
        end else if (sck_rise) begin
          committed_nxt = 1'b1;
        end else if (sck_fall && committed_r) begin
          shift_nxt = {shift_r[30:0], 1'b0};
          bit_cnt_nxt = bit_cnt_r + 6'h01;
          if (bit_cnt_r == adc_seq_pkg::LAST_BIT) begin
            st_nxt = S_CONV;
            cnt_nxt = 16'h0000;
            ch_nxt = ~ch_r;
            isck_nxt = 1'b0;
          end
        end
      end
    endcase
    // Read-out shows the shift register, otherwise the done flag
    if (st_nxt == S_OUT) begin
      sdo_nxt = shift_nxt[31];
    end else begin
      sdo_nxt = (st_nxt != S_SLEEP);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= S_POR;
      ch_r <= 1'b0;
      shift_r <= 32'h0000_0000;
      bit_cnt_r <= 6'h00;
      committed_r <= 1'b0;
      ext_mode_r <= 1'b0;
      cnt_r <= 16'h0000;
      isck_r <= 1'b0;
      half_r <= 2'h0;
      sdo_r <= 1'b1;
      cs_q_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      committed_r <= committed_nxt;
      ext_mode_r <= ext_mode_nxt;
      cnt_r <= cnt_nxt;
      isck_r <= isck_nxt;
      half_r <= half_nxt;
      sdo_r <= sdo_nxt;
      cs_q_r <= cs_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign sdo_out = sdo_r;
  assign sdo_oe_n = cs_n_s;
  assign sck_out = isck_r;
  assign sck_oe_n = ~(st_r == S_OUT && !ext_mode_r);
  assign sck_pullup_en = ~ext_mode_r;
  assign conv_busy = (st_r == S_CONV);
  assign cal_active = (st_r == S_CONV) &&
                      (int'(cnt_r) + adc_seq_pkg::CAL_TICKS >= CONV_TICKS);
  assign chan_sel = ch_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sdo_float_a: assert property (cs_n_s |-> sdo_oe_n) else $error("data output driven");
  first_chan_a: assert property (st_r == S_POR && st_nxt == S_CONV |=> !ch_r && st_r == S_CONV)
    else $error("first conversion not on channel 0");
  chan_alt_a: assert property ($past(st_r) == S_OUT && st_r == S_CONV |-> ch_r != $past(ch_r))
    else $error("channel did not alternate");
  sleep_hold_a: assert property (st_r == S_SLEEP && $past(st_r) == S_SLEEP |-> $stable(shift_r))
    else $error("result changed in sleep");
  sleep_stay_a: assert property (st_r == S_SLEEP && cs_n_s |=> st_r == S_SLEEP)
    else $error("left sleep with select high");
  wake_out_a: assert property (st_r == S_SLEEP && !cs_n_s |=> st_r == S_OUT && !sdo_oe_n)
    else $error("no wake on select low");
  early_abort_a: assert property (st_r == S_OUT && !committed_r && cs_n_s |=> st_r == S_SLEEP)
    else $error("uncommitted read did not return to sleep");
  commit_rise_a: assert property (st_r == S_OUT && !cs_n_s && sck_rise |=> committed_r)
    else $error("first rise did not commit");
  abort_conv_a: assert property (st_r == S_OUT && committed_r && cs_n_s
    |=> st_r == S_CONV && cnt_r == 16'h0000) else $error("abort did not convert");
  end_of_word_a: assert property (st_r == S_OUT && !cs_n_s && committed_r && sck_fall &&
    bit_cnt_r == 6'h1f |=> st_r == S_CONV && sdo_r) else $error("bad end of word");
  status_bit_a: assert property ((st_r == S_CONV |-> sdo_r) and (st_r == S_SLEEP |-> !sdo_r))
    else $error("wrong done flag");
  sck_idle_a: assert property (st_r != S_OUT |=> !isck_r) else $error("clock left running");
  sck_half_a: assert property ($rose(isck_r) |-> isck_r [*4]) else $error("clock high too short");

  full_read_c: cover property (st_r == S_OUT && sck_fall && bit_cnt_r == 6'h1f);
  early_abort_c: cover property (st_r == S_OUT && !committed_r && cs_n_s);
  mid_abort_c: cover property (st_r == S_OUT && committed_r && cs_n_s && bit_cnt_r > 6'h04);
  ext_read_c: cover property (st_r == S_OUT && ext_mode_r && sck_fall);

endmodule // adc_sequencer

// ===== core/sync2.sv
// Two-flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // sync2

// ===== sim/host_model.sv
// Host controller model that drives select and serial clock and captures data
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic sck_pin,
  input wire logic sdo_pin,
  output logic cs_n,
  output logic sck_drv,
  output logic sck_drv_en
);
  // ----------------------------------------------------------------
  // Host transfers
  // ----------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    sck_drv = 1'b0;
    sck_drv_en = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic set_cs(input logic v);
    hold(1);
    cs_n = v;
    hold(8);
  endtask

  // Clock level low ahead of select fall picks host clocking
  task automatic read_ext(input int nbits, output logic [31:0] w, output logic tail);
    w = '0;
    sck_drv_en = 1'b1;
    sck_drv = 1'b0;
    hold(2);
    cs_n = 1'b0;
    hold(8);
    for (int i = 0; i < nbits; i++) begin
      w = {w[30:0], sdo_pin};
      sck_drv = 1'b1;
      hold(8);
      sck_drv = 1'b0;
      hold(8);
    end
    tail = sdo_pin;
    cs_n = 1'b1;
    hold(8);
  endtask

  // Clock held high across select fall picks device clocking
  task automatic read_int(output logic [31:0] w, output int rises, output int span);
    logic prev;
    int t;
    int first;
    w = '0;
    rises = 0;
    span = 0;
    first = 0;
    prev = 1'b1;
    sck_drv_en = 1'b1;
    sck_drv = 1'b1;
    hold(2);
    cs_n = 1'b0;
    hold(2);
    sck_drv_en = 1'b0;
    // Window ends before the next conversion can finish and wake a read
    for (t = 0; t < 11000; t++) begin
      @(posedge clk);
      #1;
      if (sck_pin && !prev) begin
        w = {w[30:0], sdo_pin};
        if (rises == 0) first = t;
        span = t - first;
        rises++;
      end
      prev = sck_pin;
    end
    #1;
    cs_n = 1'b1;
    hold(8);
    sck_drv_en = 1'b1;
    hold(2);
  endtask
endmodule // host_model

// ===== sim/testbench.sv
// Self-checking bench of the converter sequencer against the host model
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Stimulus, pins and checks
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst;
  logic osc_on;
  logic osc;
  logic notch_lvl;
  logic notch_pin;
  logic [29:0] fe_code;
  logic fe_over;
  logic fe_under;
  logic cs_n, sck_drv, sck_drv_en, sck_pin, sdo_pin;
  logic sck_out, sck_oe_n, sck_pullup_en, sdo_out, sdo_oe_n;
  logic conv_busy, cal_active, chan_sel, ext_osc_active;
  logic [31:0] w;
  logic tail;
  int fails = 0;
  int checked = 0;
  int n, rises, span;

  always #25 clk = ~clk;

  // Oscillator on the frequency pin, 40 clocks a period
  always begin
    repeat (20) @(posedge clk);
    #2;
    osc = ~osc;
  end

  assign sck_pin = !sck_oe_n ? sck_out : (sck_drv_en ? sck_drv : sck_pullup_en);
  assign sdo_pin = sdo_oe_n ? ~sdo_out : sdo_out;
  assign notch_pin = osc_on ? osc : notch_lvl;

  adc_sequencer #(.CONV_TICKS(40), .POR_CYC(20), .EXT_HOLD_CYC(64)) adc_sequencer_i (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck_in(sck_pin), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .notch_freq_select_pin(notch_pin),
    .fe_code(fe_code), .fe_over(fe_over), .fe_under(fe_under), .conv_busy(conv_busy),
    .cal_active(cal_active), .chan_sel(chan_sel), .ext_osc_active(ext_osc_active));

  host_model host_model_i (.clk(clk), .sck_pin(sck_pin), .sdo_pin(sdo_pin),
    .cs_n(cs_n), .sck_drv(sck_drv), .sck_drv_en(sck_drv_en));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (conv_busy !== lvl && n < lim) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk(conv_busy, lvl);
  endtask

  // Clocks until the running conversion, or else the next one, ends
  task automatic measure(input int lo, input int hi);
    wait_busy(1'b1, 300);
    wait_busy(1'b0, 8000);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    osc_on = 1'b1;
    osc = 1'b0;
    notch_lvl = 1'b0;
    fe_code = 30'h0abc_de12;
    fe_over = 1'b0;
    fe_under = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    chk({sdo_out, sdo_oe_n, sck_oe_n, sck_pullup_en, conv_busy, chan_sel}, 6'h3c);
    rst = 1'b0;
    measure(1550, 1650);
    chk(ext_osc_active, 1'b1);
    host_model_i.hold(200);
    chk({conv_busy, cal_active, sdo_oe_n}, 3'b001);
    host_model_i.set_cs(1'b0);
    chk({sdo_oe_n, sdo_out}, 2'b00);
    host_model_i.set_cs(1'b1);
    chk({conv_busy, sdo_oe_n}, 2'b01);
    host_model_i.read_ext(32, w, tail);
    chk(w, {2'b00, fe_code});
    chk(tail, 1'b1);
    chk({conv_busy, cal_active, chan_sel}, 3'b111);
    fe_over = 1'b1;
    measure(1520, 1650);
    host_model_i.read_ext(32, w, tail);
    chk(w, {2'b01, adc_seq_pkg::OVER_CODE});
    fe_over = 1'b0;
    fe_under = 1'b1;
    wait_busy(1'b0, 2000);
    host_model_i.read_ext(5, w, tail);
    chk(w[4:0], 5'h01);
    chk({conv_busy, sdo_oe_n, chan_sel}, 3'b111);
    wait_busy(1'b0, 2000);
    host_model_i.read_ext(32, w, tail);
    chk(w, {2'b01, adc_seq_pkg::UNDER_CODE});
    fe_under = 1'b0;
    fe_code = 30'h1234_5678;
    wait_busy(1'b0, 2000);
    host_model_i.read_int(w, rises, span);
    chk(rises, 32);
    chk(32'(span >= 9915 && span <= 9925), 32'h1);
    chk(w, {2'b00, 30'h1234_5678});
    chk(sck_pullup_en, 1'b1);
    osc_on = 1'b0;
    host_model_i.hold(150);
    chk(ext_osc_active, 1'b0);
    wait_busy(1'b0, 8000);
    host_model_i.read_ext(32, w, tail);
    chk({sck_pullup_en, w[31:29]}, {1'b0, 2'b01, fe_code[29]});
    measure(5050, 5340);
    notch_lvl = 1'b1;
    host_model_i.read_ext(32, w, tail);
    chk(w[31:30], 2'b00);
    measure(6060, 6400);
    wrap_up();
  end
endmodule // testbench
